// File: hw/sgo_gate_logic.sv
`timescale 1ns/100ps
module sgo_gate_logic import sgo_pkg::*; #(
  parameter int ID_W = 32,
  parameter longint TEACH_WAIT_CYC = SGO_TEACH_WAIT_CYC,
  parameter longint CONFIRM_CYC = SGO_CONFIRM_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Device status and supply return after an interruption.
  input wire logic device_ready,
  input wire logic supply_restored,
  // Transponder front end.
  input wire logic actuator_present,
  input wire logic single_transponder,
  input wire logic [ID_W-1:0] actuator_id,
  // Daisy-chain safety inputs.
  input wire logic safety_in_ch1,
  input wire logic safety_in_ch2,
  // Safety and signal outputs.
  output logic output_switching_device_signal_ch1,
  output logic output_switching_device_signal_ch2,
  output logic presence_signal_out,
  // Indicators.
  output logic led_power_green,
  output logic led_gate_yellow,
  output logic led_input_yellow,
  // Remaining replacement teach-ins.
  output logic [3:0] learn_left
);

  // *************************************************************
  // Declarations
  // *************************************************************

  // Stored history of every actuator taught so far.
  logic [ID_W-1:0] hist_reg [0:SGO_LEARN_MAX];
  logic [SGO_LEARN_MAX:0] hist_vld_reg;
  logic [SGO_LEARN_MAX:0] hist_vld_next;
  // Currently adopted actuator.
  logic [ID_W-1:0] taught_id_reg;
  logic [ID_W-1:0] taught_id_next;
  logic taught_vld_reg;
  logic taught_vld_next;
  logic [3:0] learn_reg;
  logic [3:0] learn_next;
  logic [3:0] hist_cnt_reg;
  logic [3:0] hist_cnt_next;
  logic hist_wr;
  // Teach-in sequencer.
  sgo_tch_state_t tch_reg;
  sgo_tch_state_t tch_next;
  logic [ID_W-1:0] cand_reg;
  logic [ID_W-1:0] cand_next;
  logic [SGO_TMR_W-1:0] tmr_reg;
  logic [SGO_TMR_W-1:0] tmr_next;
  // Input supervision.
  sgo_in_state_t in_reg;
  sgo_in_state_t in_next;
  logic [1:0] prev_reg;
  logic [1:0] fell_reg;
  logic [1:0] fell_next;
  // Blink divider.
  logic [SGO_BLINK_W-1:0] blink_reg;
  // Next divider value, one count up each cycle.
  logic [SGO_BLINK_W-1:0] blink_next;
  // Output flip-flops.
  logic out1_reg;
  logic out2_reg;
  logic sig_reg;
  logic pwr_reg;
  logic gate_reg;
  logic inp_reg;
  logic [5:0] outs_next;
  // Decoded conditions.
  logic known;
  logic seen;
  logic [1:0] now_in;

  // Reports whether an identity is already in the history.
  function automatic logic in_hist(input logic [ID_W-1:0] id);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i <= SGO_LEARN_MAX; i++) begin
      if (hist_vld_reg[i] && hist_reg[i] == id) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign known = actuator_present && taught_vld_reg &&
                 actuator_id == taught_id_reg;
  assign seen = in_hist(actuator_id);
  assign now_in = {safety_in_ch2, safety_in_ch1};

  // *************************************************************
  // Teach-in sequencing
  // *************************************************************

  // Computes the next teach state, timer and stored actuator data.
  always_comb begin
    tch_next = tch_reg;
    cand_next = cand_reg;
    tmr_next = tmr_reg + SGO_TMR_W'(1);
    taught_id_next = taught_id_reg;
    taught_vld_next = taught_vld_reg;
    learn_next = learn_reg;
    hist_cnt_next = hist_cnt_reg;
    hist_vld_next = hist_vld_reg;
    hist_wr = 1'b0;
    unique case (tch_reg)
      SGO_TCH_IDLE: begin
        tmr_next = '0;
        if (device_ready && actuator_present &&
            single_transponder) begin
          if (!taught_vld_reg) begin
            // First actuator is adopted at once, no count used.
            taught_id_next = actuator_id;
            taught_vld_next = 1'b1;
            hist_wr = 1'b1;
          end else if (!known && !seen &&
                       learn_reg != '0) begin
            cand_next = actuator_id;
            tch_next = SGO_TCH_SLOW;
          end
        end
      end
      SGO_TCH_SLOW: begin
        // Candidate must stay alone and unchanged in range.
        if (!actuator_present || !single_transponder ||
            actuator_id != cand_reg) begin
          tch_next = SGO_TCH_IDLE;
        end else if (tmr_reg >= SGO_TMR_W'(TEACH_WAIT_CYC - 1)) begin
          tmr_next = '0;
          tch_next = SGO_TCH_FAST;
        end
      end
      SGO_TCH_FAST: begin
        if (supply_restored) begin
          // Power returned inside the window: adopt the candidate.
          taught_id_next = cand_reg;
          learn_next = learn_reg - SGO_LEARN_STEP;
          hist_wr = 1'b1;
          tch_next = SGO_TCH_IDLE;
        end else if (!actuator_present || actuator_id != cand_reg) begin
          tch_next = SGO_TCH_IDLE;
        end else if (tmr_reg >= SGO_TMR_W'(CONFIRM_CYC - 1)) begin
          tch_next = SGO_TCH_DONE;
        end
      end
      SGO_TCH_DONE: begin
        // Timed out; wait for the candidate to leave before retrying.
        tmr_next = '0;
        if (!actuator_present || actuator_id != cand_reg) begin
          tch_next = SGO_TCH_IDLE;
        end
      end
    endcase
    if (hist_wr && hist_cnt_reg <= SGO_LEARN_MAX) begin
      hist_vld_next[hist_cnt_reg] = 1'b1;
      hist_cnt_next = hist_cnt_reg + 4'h1;
    end
  end

  // Registers the teach state and the actuator store.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tch_reg <= SGO_TCH_IDLE;
      cand_reg <= '0;
      tmr_reg <= '0;
      taught_id_reg <= '0;
      taught_vld_reg <= 1'b0;
      learn_reg <= SGO_LEARN_MAX;
      hist_cnt_reg <= '0;
      hist_vld_reg <= '0;
    end else begin
      tch_reg <= tch_next;
      cand_reg <= cand_next;
      tmr_reg <= tmr_next;
      taught_id_reg <= taught_id_next;
      taught_vld_reg <= taught_vld_next;
      learn_reg <= learn_next;
      hist_cnt_reg <= hist_cnt_next;
      hist_vld_reg <= hist_vld_next;
    end
  end

  // Writes the history memory; only valid entries are ever read.
  always_ff @(posedge clk) begin
    if (hist_wr && hist_cnt_reg <= SGO_LEARN_MAX) begin
      hist_reg[hist_cnt_reg] <= taught_id_next;
    end
  end

  // *************************************************************
  // Input consistency supervision
  // *************************************************************

  // Tracks unequal transitions and the partial operation lock.
  always_comb begin
    in_next = in_reg;
    fell_next = fell_reg;
    if (now_in == 2'h0) begin
      // Both low together clears any unequal or locked state.
      in_next = SGO_IN_OK;
      fell_next = '0;
    end else begin
      unique case (in_reg)
        SGO_IN_OK: begin
          if (prev_reg == 2'h3 && (now_in == 2'h1 || now_in == 2'h2)) begin
            in_next = SGO_IN_UNEQ;
            fell_next = ~now_in;
          end
        end
        SGO_IN_UNEQ: begin
          if (now_in == 2'h3) begin
            in_next = SGO_IN_LOCK;
          end
        end
        SGO_IN_LOCK: begin
          in_next = SGO_IN_LOCK;
        end
        default: begin
          in_next = SGO_IN_LOCK;
        end
      endcase
    end
  end

  // Registers the supervision state; a supply return starts clean.
  always_ff @(posedge clk) begin
    if (sys_rst || supply_restored) begin
      in_reg <= SGO_IN_OK;
      fell_reg <= '0;
      prev_reg <= '0;
    end else begin
      in_reg <= in_next;
      fell_reg <= fell_next;
      prev_reg <= now_in;
    end
  end

  // *************************************************************
  // Outputs and indicators
  // *************************************************************

  // Computes every output; not ready gives all low, no actuator gives the safety and signal outputs low.
  always_comb begin
    outs_next = '0;
    blink_next = blink_reg + SGO_BLINK_W'(1);
    outs_next[3] = device_ready;
    if (device_ready && known) begin
      // Locked channel stays low until both inputs were low or the supply returns.
      outs_next[0] = safety_in_ch1 && !fell_reg[0];
      outs_next[1] = safety_in_ch2 && !fell_reg[1];
      outs_next[2] = 1'b1;
    end
    if (device_ready) begin
      unique case (tch_reg)
        SGO_TCH_SLOW: outs_next[4] = blink_reg[SGO_SLOW_BIT];
        SGO_TCH_FAST: outs_next[4] = blink_reg[SGO_FAST_BIT];
        SGO_TCH_IDLE, SGO_TCH_DONE: outs_next[4] = known;
      endcase
      if (in_reg != SGO_IN_OK) begin
        outs_next[5] = blink_reg[SGO_SLOW_BIT];
      end else begin
        outs_next[5] = now_in == 2'h3;
      end
    end
  end

  // Registers outputs and runs the blink divider.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blink_reg <= '0;
      {inp_reg, gate_reg, pwr_reg, sig_reg, out2_reg, out1_reg} <= '0;
    end else begin
      blink_reg <= blink_next;
      {inp_reg, gate_reg, pwr_reg, sig_reg, out2_reg, out1_reg} <= outs_next;
    end
  end

  assign output_switching_device_signal_ch1 = out1_reg;
  assign output_switching_device_signal_ch2 = out2_reg;
  assign presence_signal_out = sig_reg;
  assign led_power_green = pwr_reg;
  assign led_gate_yellow = gate_reg;
  assign led_input_yellow = inp_reg;
  assign learn_left = learn_reg;

endmodule

// File: pkg/sgo_pkg.sv
package sgo_pkg;

  // *************************************************************
  // Timing figures
  // *************************************************************

  // Core clock rate in hertz.
  localparam longint SGO_CLK_HZ = 125_000_000;
  // Candidate dwell time before fast flashing, in seconds.
  localparam longint SGO_TEACH_WAIT_S = 20;
  // Confirmation window after fast flashing starts, in seconds.
  localparam longint SGO_CONFIRM_S = 120;
  // Derived cycle counts; the window is a longest time, both exact.
  localparam longint SGO_TEACH_WAIT_CYC = SGO_TEACH_WAIT_S * SGO_CLK_HZ;
  localparam longint SGO_CONFIRM_CYC = SGO_CONFIRM_S * SGO_CLK_HZ;
  // Timer width large enough for the confirmation window.
  localparam int SGO_TMR_W = 34;

  // *************************************************************
  // Learning and display constants
  // *************************************************************

  // Number of replacement teach-in procedures allowed.
  localparam logic [3:0] SGO_LEARN_MAX = 4'h8;
  // Decrement applied per confirmed teach-in.
  localparam logic [3:0] SGO_LEARN_STEP = 4'h1;
  // Width of the indicator blink divider.
  localparam int SGO_BLINK_W = 26;
  // Divider bit giving the normal and the fast flash rate.
  localparam int SGO_SLOW_BIT = 25;
  localparam int SGO_FAST_BIT = 23;

  // *************************************************************
  // State types
  // *************************************************************

  // Input consistency supervision.
  typedef enum logic [1:0] {
    SGO_IN_OK = 2'b00,
    SGO_IN_UNEQ = 2'b01,
    SGO_IN_LOCK = 2'b10
  } sgo_in_state_t;

  // Teach-in sequence.
  typedef enum logic [1:0] {
    SGO_TCH_IDLE = 2'b00,
    SGO_TCH_SLOW = 2'b01,
    SGO_TCH_FAST = 2'b10,
    SGO_TCH_DONE = 2'b11
  } sgo_tch_state_t;

endpackage

// File: testbench/sgo_eval_model.sv
`timescale 1ns/100ps
// Evaluation device: drives the chain inputs, reads the safety outputs.
module sgo_eval_model (
  // Clock.
  input wire logic clk,
  // Levels asked for by the scenario.
  input wire logic cmd_ch1,
  input wire logic cmd_ch2,
  // Safety outputs read back.
  input wire logic osd_ch1,
  input wire logic osd_ch2,
  // Chain levels into the switch.
  output logic safety_in_ch1,
  output logic safety_in_ch2,
  // High once the outputs disagreed since both were last low.
  output logic feas_fault
);
  initial begin
    safety_in_ch1 = 1'b0;
    safety_in_ch2 = 1'b0;
    feas_fault = 1'b0;
  end
  // Inputs follow the request one edge later; channels are watched as a pair.
  always @(posedge clk) begin
    safety_in_ch1 <= cmd_ch1;
    safety_in_ch2 <= cmd_ch2;
    if (!osd_ch1 && !osd_ch2) begin
      feas_fault <= 1'b0;
    end else if (osd_ch1 != osd_ch2) begin
      feas_fault <= 1'b1;
    end
  end
endmodule

// File: testbench/sgo_gate_checker.sv
`timescale 1ns/100ps
// ****************************************
// Port checker for the gate output logic.
// ****************************************
module sgo_gate_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs of the block.
  input wire logic device_ready,
  input wire logic supply_restored,
  input wire logic actuator_present,
  input wire logic safety_in_ch1,
  input wire logic safety_in_ch2,
  // Outputs of the block.
  input wire logic output_switching_device_signal_ch1,
  input wire logic output_switching_device_signal_ch2,
  input wire logic presence_signal_out,
  input wire logic led_power_green,
  input wire logic [3:0] learn_left
);
  // Short aliases keep the properties on one line.
  wire logic o1 = output_switching_device_signal_ch1;
  wire logic o2 = output_switching_device_signal_ch2;
  wire logic i1 = safety_in_ch1;
  wire logic i2 = safety_in_ch2;
  wire logic pso = presence_signal_out;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Not ready forces every safety and signal output low a cycle later.
  not_ready_a:
    assert property (!device_ready |=> !o1 && !o2 && !pso)
    else $error("Output high while the unit is not ready.");
  // The ready indicator follows readiness with one cycle of latency.
  power_led_a:
    assert property (device_ready |=> led_power_green)
    else $error("Ready indicator does not follow readiness.");
  // The ready indicator goes dark once readiness is lost.
  power_off_a:
    assert property (!device_ready |=> !led_power_green)
    else $error("Ready indicator lit while the unit is not ready.");
  // With nothing in range the outputs stay low whatever the inputs do.
  no_actuator_a:
    assert property (!actuator_present |=> !o1 && !o2 && !pso)
    else $error("Output high with no actuator in range.");
  // Each safety output is low one cycle after its own input is low.
  ch1_follow_a:
    assert property (!i1 |=> !o1)
    else $error("Channel one output high with its input low.");
  ch2_follow_a:
    assert property (!i2 |=> !o2)
    else $error("Channel two output high with its input low.");
  // The signal output needs readiness and presence a cycle earlier.
  presence_cause_a:
    assert property (pso |-> $past(device_ready) &&
      $past(actuator_present))
    else $error("Signal output high without a cause.");
  // The count only steps down by one, right after a supply return.
  learn_step_a:
    assert property ($changed(learn_left) |->
      $past(supply_restored) && learn_left == $past(learn_left) - 4'h1)
    else $error("Learn count changed other than by one on power-up.");
  // A refused rise on channel one keeps that output low.
  lock_ch1_a:
    assert property (!supply_restored throughout
      ((!i1 && !i2) ##1 (i1 && i2) [*3] ##1 (!i1 && i2) [*3] ##1
      (i1 && i2)) |=> !o1)
    else $error("Channel one not locked after a refused rise.");
endmodule
bind sgo_gate_logic sgo_gate_checker chk_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .device_ready(device_ready),
  .supply_restored(supply_restored),
  .actuator_present(actuator_present),
  .safety_in_ch1(safety_in_ch1),
  .safety_in_ch2(safety_in_ch2),
  .output_switching_device_signal_ch1(output_switching_device_signal_ch1),
  .output_switching_device_signal_ch2(output_switching_device_signal_ch2),
  .presence_signal_out(presence_signal_out),
  .led_power_green(led_power_green),
  .learn_left(learn_left)
);

// File: testbench/sgo_gate_logic_tb_top.sv
`timescale 1ns/100ps
module sgo_gate_logic_tb_top;
  logic clk = 1'b0;
  logic sys_rst, rdy, sup, act, sgl, c1, c2;
  logic [31:0] aid;
  logic s1, s2, o1, o2, pso, lp, lg, li, ff;
  logic [3:0] ll;
  wire logic [3:0] outs = {1'b0, o1, o2, pso};
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  sgo_gate_logic #(.TEACH_WAIT_CYC(20), .CONFIRM_CYC(50)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .device_ready(rdy),
    .supply_restored(sup), .actuator_present(act),
    .single_transponder(sgl), .actuator_id(aid),
    .safety_in_ch1(s1), .safety_in_ch2(s2),
    .output_switching_device_signal_ch1(o1),
    .output_switching_device_signal_ch2(o2),
    .presence_signal_out(pso), .led_power_green(lp),
    .led_gate_yellow(lg), .led_input_yellow(li), .learn_left(ll));
  sgo_eval_model eval_u (
    .clk(clk), .cmd_ch1(c1), .cmd_ch2(c2), .osd_ch1(o1), .osd_ch2(o2),
    .safety_in_ch1(s1), .safety_in_ch2(s2), .feas_fault(ff));
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Requests chain levels for exactly three cycles.
  task automatic hold(logic a, logic b);
    @(posedge clk);
    c1 <= a;
    c2 <= b;
    wt(2);
  endtask
  // Offers a candidate for n cycles, then cycles the supply.
  task automatic teach(logic [31:0] id, logic one, int n, logic [3:0] e);
    @(posedge clk);
    aid <= id;
    sgl <= one;
    act <= 1'b1;
    repeat (n) @(posedge clk);
    sup <= 1'b1;
    @(posedge clk);
    sup <= 1'b0;
    act <= 1'b0;
    wt(2);
    chk("learn_left", e, ll);
  endtask
  task automatic t_first;
    @(posedge clk);
    {act, sgl, aid} <= {2'b11, 32'h0000_00A1};
    hold(0, 0);
    chk("outs 00", 4'h1, outs);
    hold(1, 0);
    chk("outs 10", 4'h5, outs);
    hold(0, 1);
    chk("outs 01", 4'h3, outs);
    hold(1, 1);
    chk("outs 11", 4'h7, outs);
    chk("learn_left", 4'h8, ll);
    chk("gate led", 4'h1, {3'h0, lg});
  endtask
  task automatic t_ready;
    @(posedge clk);
    rdy <= 1'b0;
    wt(2);
    chk("outs off", 4'h0, outs);
    chk("power led", 4'h0, {3'h0, lp});
    @(posedge clk);
    rdy <= 1'b1;
    act <= 1'b0;
    wt(2);
    chk("outs absent", 4'h0, outs);
    chk("gate off", 4'h0, {3'h0, lg});
    @(posedge clk);
    act <= 1'b1;
    wt(2);
    chk("outs back", 4'h7, outs);
    chk("power on", 4'h1, {3'h0, lp});
  endtask
  // The evaluator flag lags the outputs by one edge, so it is read
  // after the following step. The slow flash phase is still dark this
  // early after reset, so a flashing indicator reads low.
  task automatic t_lock;
    hold(0, 0);
    hold(1, 1);
    chk("input led", 4'h1, {3'h0, li});
    hold(0, 1);
    chk("outs uneq", 4'h3, outs);
    hold(1, 1);
    chk("outs lock", 4'h3, outs);
    chk("lock led", 4'h0, {3'h0, li});
    chk("fault flag", 4'h1, {3'h0, ff});
    hold(0, 0);
    hold(1, 1);
    chk("outs free", 4'h7, outs);
    chk("fault clr", 4'h0, {3'h0, ff});
  endtask
  task automatic t_teach;
    teach(32'h0000_00B1, 1'b1, 30, 4'h7);
    teach(32'h0000_00A1, 1'b1, 30, 4'h7);
    teach(32'h0000_00C1, 1'b0, 30, 4'h7);
    teach(32'h0000_00C1, 1'b1, 10, 4'h7);
    teach(32'h0000_00C1, 1'b1, 90, 4'h7);
    for (int i = 0; i < 7; i++) begin
      teach(32'h0000_00E0 + i, 1'b1, 30, 4'(6 - i));
    end
    teach(32'h0000_00F0, 1'b1, 30, 4'h0);
    @(posedge clk);
    {act, aid} <= {1'b1, 32'h0000_00E6};
    wt(3);
    chk("new taught", 4'h7, outs);
    chk("new gate", 4'h1, {3'h0, lg});
    @(posedge clk);
    aid <= 32'h0000_00B1;
    wt(3);
    chk("old one", 4'h0, outs);
    chk("old gate", 4'h0, {3'h0, lg});
  endtask
  initial begin
    {sys_rst, rdy, sup, act, sgl, c1, c2} = 7'h40;
    aid = 32'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rdy <= 1'b1;
    wt(2);
    chk("reset count", 4'h8, ll);
    chk("reset outs", 4'h0, outs);
    t_first;
    t_ready;
    t_lock;
    t_teach;
    final_report;
  end
endmodule
